/* rtl/sap_ctrl.sv */
// Purpose: Main control of a mono 16-bit serial audio port with two 32-word queues
// Assumes: APB slave on pclk; shift clock derived from pclk by enable pulses
// Notes: Overview of operation follows
// Overview of operation
// - Tx threshold bits 18:13; nearly-empty below it
// - Tx nearly-full above 32 minus threshold
// - Zero tx threshold makes tx flags meaningless
// - Rx threshold bits 12:7, same flag pair
// - Bit 6: tx DMA request while not nearly-full
// - Bit 5: rx DMA request while not empty
// - Bit 4: tx MSB with sync or after
// - Bit 3: rx MSB sampled with sync or after
// - Bits 2/1 enable tx/rx queue
// - Clearing a queue enable discards its contents
// - Bit 0 runs the shift state machines
// - Bit 0 low: output quiet, counters reset
// - Clock bit 19 runs shift clock, sync
// - Each queue holds 32 words of 16 bits
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "sap_defines.svh"

module sap_ctrl
    import sap_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    output logic shift_clock,
    output logic frame_sync,
    output logic serial_out,
    input wire logic serial_in,
    // DMA requests
    output logic tx_dma_req,
    output logic rx_dma_req,
    // Queue flags
    output logic tx_nearly_empty,
    output logic tx_nearly_full,
    output logic rx_nearly_empty,
    output logic rx_nearly_full,
    output logic rx_queue_empty
);

////////////////////////////////////////////////////////////////////////////////

function automatic logic mapped(input logic [11:0] a);
    return a == `SAP_OFS_CTL || a == `SAP_OFS_CLK || a == `SAP_OFS_TXQ ||
        a == `SAP_OFS_RXQ || a == `SAP_OFS_STAT;
endfunction

// Flags are raw compares; a zero threshold gives no useful answer
function automatic logic [1:0] near_flags(input sap_cnt_t cnt, input sap_cnt_t th);
    logic ne;
    logic nf;
    ne = {1'b0, cnt} < {1'b0, th};
    // Sum form keeps a threshold above 32 from wrapping into a huge bound
    nf = 7'({1'b0, cnt} + {1'b0, th}) > `SAP_DEPTH;
    return {nf, ne};
endfunction

sap_state_s s;
sap_state_s n;
logic setup;
logic acc_wr;
logic acc_rd;
sap_cnt_t tx_th;
sap_cnt_t rx_th;
logic tpush;
logic tpop;
logic rpush;
logic rpop;
sap_word_t rword;
sap_word_t twd;
logic [8:0] ncyc;
logic [1:0] tfl;
logic [1:0] rfl;

assign setup = psel & ~penable;
assign acc_wr = psel & penable & pwrite;
assign acc_rd = psel & penable & ~pwrite;
assign tx_th = s.ctl[`SAP_TXTH_HI:`SAP_TXTH_LO];
assign rx_th = s.ctl[`SAP_RXTH_HI:`SAP_RXTH_LO];
assign tfl = near_flags(s.tcnt, tx_th);
assign rfl = near_flags(s.rcnt, rx_th);
assign twd = s.tmem[s.trp];

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    n = s;
    tpop = 1'b0;
    rpush = 1'b0;
    rword = s.rsh;
    ncyc = s.cyc;
    // Only the second and third stages are compared
    n.s1 = serial_in;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
        n.sin = s.s3;
    end
    // Read data is captured in setup so the access phase needs no wait
    if (setup) begin
        n.slverr = ~mapped(paddr);
        unique case (paddr)
            `SAP_OFS_CTL: n.prdata = {13'h0000, s.ctl};
            `SAP_OFS_CLK: n.prdata = {12'h000, s.clk};
            `SAP_OFS_TXQ: n.prdata = {15'h0000, s.tcnt != 6'h00, twd};
            `SAP_OFS_RXQ: n.prdata = {15'h0000, s.rcnt != 6'h00, s.rmem[s.rrp]};
            `SAP_OFS_STAT: n.prdata = {11'h000, s.rcnt == 6'h00, rfl[1], rfl[0],
                tfl[1], tfl[0], 4'h0, s.rcnt, s.tcnt};
            default: n.prdata = 32'h00000000;
        endcase
    end
    if (acc_wr && paddr == `SAP_OFS_CTL) begin
        n.ctl = pwdata[`SAP_CTL_W-1:0];
    end
    if (acc_wr && paddr == `SAP_OFS_CLK) begin
        n.clk = pwdata[`SAP_CLK_W-1:0];
    end
    // Shift engine
    if (!s.ctl[`SAP_RUN_BIT]) begin
        n.div = 9'h000;
        n.cyc = 9'h000;
        n.sclk = 1'b0;
        n.fs = 1'b0;
        n.sout = 1'b0;
        n.first = 1'b1;
    end else if (s.clk[`SAP_SCLKEN_BIT]) begin
        if (s.div == s.clk[`SAP_SCLKDIV_HI:`SAP_SCLKDIV_LO]) begin
            n.div = 9'h000;
            n.sclk = ~s.sclk;
            if (!s.sclk) begin
                // Rising edge opens a new shift-clock cycle
                if (s.first || s.cyc >= s.clk[`SAP_SYNCDIV_HI:`SAP_SYNCDIV_LO]) begin
                    ncyc = 9'h000;
                end else begin
                    ncyc = 9'(s.cyc + 9'h001);
                end
                n.cyc = ncyc;
                n.first = 1'b0;
                n.fs = ncyc == 9'h000;
                if (ncyc == 9'h000) begin
                    // An empty queue sends silence rather than stale data
                    tpop = s.ctl[`SAP_TXEN_BIT] && s.tcnt != 6'h00;
                    if (!s.ctl[`SAP_TXPOS_BIT]) begin
                        n.sout = tpop ? twd[15] : 1'b0;
                        n.tsh = tpop ? {twd[14:0], 1'b0} : 16'h0000;
                    end else begin
                        n.sout = 1'b0;
                        n.tsh = tpop ? twd : 16'h0000;
                    end
                end else if (ncyc < 9'(9'h010 + {8'h00, s.ctl[`SAP_TXPOS_BIT]})) begin
                    n.sout = s.tsh[15];
                    n.tsh = {s.tsh[14:0], 1'b0};
                end else begin
                    n.sout = 1'b0;
                end
            end else if (!s.first) begin
                // Falling edge samples the input within the current cycle
                if (s.cyc >= {8'h00, s.ctl[`SAP_RXPOS_BIT]} &&
                        s.cyc < 9'(9'h010 + {8'h00, s.ctl[`SAP_RXPOS_BIT]})) begin
                    rword = {s.rsh[14:0], s.sin};
                    n.rsh = rword;
                    rpush = s.cyc == 9'(9'h00F + {8'h00, s.ctl[`SAP_RXPOS_BIT]});
                end
            end
        end else begin
            n.div = 9'(s.div + 9'h001);
        end
    end
    // Transmit queue
    tpush = acc_wr && paddr == `SAP_OFS_TXQ && s.ctl[`SAP_TXEN_BIT] &&
        s.tcnt != `SAP_CNT_W'(`SAP_DEPTH);
    if (!s.ctl[`SAP_TXEN_BIT]) begin
        n.trp = 5'h00;
        n.tcnt = 6'h00;
    end else begin
        if (tpush) begin
            n.tmem[5'(s.trp + s.tcnt[4:0])] = pwdata[`SAP_WORD_W-1:0];
        end
        if (tpop) begin
            n.trp = 5'(s.trp + 5'h01);
        end
        n.tcnt = 6'(s.tcnt + {5'h00, tpush} - {5'h00, tpop});
    end
    // Receive queue; a word arriving into a full queue is dropped
    rpop = acc_rd && paddr == `SAP_OFS_RXQ && s.prdata[`SAP_VALID_BIT] &&
        s.ctl[`SAP_RXEN_BIT];
    if (!s.ctl[`SAP_RXEN_BIT]) begin
        n.rrp = 5'h00;
        n.rcnt = 6'h00;
    end else begin
        if (rpush && s.rcnt != `SAP_CNT_W'(`SAP_DEPTH)) begin
            n.rmem[5'(s.rrp + s.rcnt[4:0])] = rword;
            n.rcnt = 6'(s.rcnt + 6'h01 - {5'h00, rpop});
        end else begin
            n.rcnt = 6'(s.rcnt - {5'h00, rpop});
        end
        if (rpop) begin
            n.rrp = 5'(s.rrp + 5'h01);
        end
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s <= '0;
        s.ctl <= `SAP_CTL_RESET;
        s.clk <= `SAP_CLK_RESET;
        s.first <= 1'b1;
    end else begin
        s <= n;
    end
end

////////////////////////////////////////////////////////////////////////////////

assign prdata = s.prdata;
assign pready = psel & penable;
assign pslverr = psel & penable & s.slverr;
assign shift_clock = s.sclk;
assign frame_sync = s.fs;
assign serial_out = s.sout;
assign tx_nearly_empty = tfl[0];
assign tx_nearly_full = tfl[1];
assign rx_nearly_empty = rfl[0];
assign rx_nearly_full = rfl[1];
assign rx_queue_empty = s.rcnt == 6'h00;
// Level requests suit a demand-mode controller
assign tx_dma_req = s.ctl[`SAP_TXDMA_BIT] & ~tfl[1];
assign rx_dma_req = s.ctl[`SAP_RXDMA_BIT] & (s.rcnt != 6'h00);

////////////////////////////////////////////////////////////////////////////////

default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

sequence s_pop_msb_same;
    tpop && !s.ctl[`SAP_TXPOS_BIT];
endsequence

sequence s_pop_msb_late;
    tpop && s.ctl[`SAP_TXPOS_BIT];
endsequence

// Rx word closes on the falling edge of its last sampled cycle
sequence s_rx_last_same;
    rpush && !s.ctl[`SAP_RXPOS_BIT];
endsequence

sequence s_rx_last_late;
    rpush && s.ctl[`SAP_RXPOS_BIT];
endsequence

// Restated in plain integers so a slip in the shared compare shows
a_tx_near_empty: assert property (
    tx_nearly_empty == (int'(tx_th) - int'(s.tcnt) > 0))
    else $error("tx nearly-empty wrong");
a_tx_near_full: assert property (
    tx_nearly_full == (32 - int'(tx_th) < int'(s.tcnt)))
    else $error("tx nearly-full wrong");
a_rx_near_flags: assert property (
    (s.rcnt == 6'h00 && rx_th != 6'h00 && rx_th <= 6'h20) |->
        rx_nearly_empty && !rx_nearly_full)
    else $error("rx flags wrong when empty");
a_rx_near_full: assert property (
    rx_nearly_full == (32 - int'(rx_th) < int'(s.rcnt)))
    else $error("rx nearly-full wrong");
a_tx_dma_req: assert property (
    tx_dma_req == (s.ctl[6] && !tx_nearly_full))
    else $error("tx dma request wrong");
a_rx_dma_req: assert property (
    (s.ctl[5] && !rx_queue_empty) |-> rx_dma_req)
    else $error("rx dma request missing");
a_msb_same: assert property (
    s_pop_msb_same |=> serial_out == $past(twd[15]) && frame_sync)
    else $error("msb not with sync");
a_msb_late: assert property (
    s_pop_msb_late |=> !serial_out ##0 frame_sync)
    else $error("msb not delayed");
a_queue_flush: assert property (
    $fell(s.ctl[2]) |-> s.tcnt == 6'($past(s.tcnt) - {5'h00, $past(tpop)}) ##1 s.tcnt == 6'h00)
    else $error("tx queue not flushed");
a_queue_gate: assert property (
    !s.ctl[2] |-> !tpop ##1 s.tcnt == 6'h00)
    else $error("disabled tx queue moved");
a_run_quiet: assert property (
    !s.ctl[0] |=> !serial_out && !shift_clock && s.div == 9'h000 && s.cyc == 9'h000)
    else $error("shifter not held");
a_run_needed: assert property (
    !s.ctl[0] |-> !tpop && !rpush)
    else $error("transfer while stopped");
a_div_hold: assert property (
    (s.ctl[0] && !s.clk[19]) [*2] |-> $stable(shift_clock) && $stable(frame_sync))
    else $error("shift clock ran while divider off");
a_depth_cap: assert property (
    s.tcnt <= 6'h20 && s.rcnt <= 6'h20)
    else $error("queue over depth");
a_count_up: assert property (
    (tpush && !tpop) |=> s.tcnt == 6'($past(s.tcnt) + 6'h01))
    else $error("tx count did not rise");
a_count_down: assert property (
    (tpop && !tpush) |=> s.tcnt == 6'($past(s.tcnt) - 6'h01))
    else $error("tx count did not fall");
a_rx_count_up: assert property (
    (rpush && s.ctl[1] && s.rcnt != 6'h20 && !rpop) |=> s.rcnt == 6'($past(s.rcnt) + 6'h01))
    else $error("rx count did not rise");
a_rx_count_down: assert property (
    (rpop && !rpush) |=> s.rcnt == 6'($past(s.rcnt) - 6'h01))
    else $error("rx count did not fall");
a_rx_flush: assert property (
    $fell(s.ctl[1]) |=> s.rcnt == 6'h00 && s.rrp == 5'h00)
    else $error("rx queue not flushed");
a_rx_dma_off: assert property (
    !s.ctl[5] |-> !rx_dma_req)
    else $error("rx dma request while disabled");
a_rx_msb_same: assert property (
    s_rx_last_same |-> shift_clock && s.cyc == 9'h00F)
    else $error("rx word not closed in cycle 15");
a_rx_msb_late: assert property (
    s_rx_last_late |-> shift_clock && s.cyc == 9'h010)
    else $error("rx word not closed in cycle 16");
a_tx_full_drop: assert property (
    (acc_wr && paddr == `SAP_OFS_TXQ && s.ctl[2] && s.tcnt == 6'h20 && !tpop) |=>
        s.tcnt == 6'h20)
    else $error("write into full tx queue counted");
a_sync_cycle: assert property (
    frame_sync |-> s.cyc == 9'h000)
    else $error("frame sync outside cycle zero");

endmodule

/* rtl/sap_defines.svh */
// Purpose: Offsets, field positions and reset values of the serial audio port
// Assumes: 32-bit APB data, one register per aligned word
// Notes: Definitions only
`ifndef SAP_DEFINES_SVH
`define SAP_DEFINES_SVH

`define SAP_OFS_CTL 12'h000
`define SAP_OFS_CLK 12'h004
`define SAP_OFS_TXQ 12'h008
`define SAP_OFS_RXQ 12'h00C
`define SAP_OFS_STAT 12'h018

`define SAP_CTL_W 19
`define SAP_CLK_W 20
`define SAP_CTL_RESET 19'h00000
`define SAP_CLK_RESET 20'h00000

`define SAP_TXTH_HI 18
`define SAP_TXTH_LO 13
`define SAP_RXTH_HI 12
`define SAP_RXTH_LO 7
`define SAP_TXDMA_BIT 6
`define SAP_RXDMA_BIT 5
`define SAP_TXPOS_BIT 4
`define SAP_RXPOS_BIT 3
`define SAP_TXEN_BIT 2
`define SAP_RXEN_BIT 1
`define SAP_RUN_BIT 0

`define SAP_SCLKEN_BIT 19
`define SAP_SCLKDIV_HI 17
`define SAP_SCLKDIV_LO 9
`define SAP_SYNCDIV_HI 8
`define SAP_SYNCDIV_LO 0

`define SAP_DEPTH 7'h20
`define SAP_WORD_W 16
`define SAP_PTR_W 5
`define SAP_CNT_W 6
`define SAP_VALID_BIT 16

`endif

/* rtl/sap_pkg.sv */
// Purpose: Types of the serial audio port control block
// Assumes: sap_defines.svh holds every number but the 9-bit divider and cycle widths, the 32-entry queue arrays and the 32-bit read data
// Notes: Whole block state is one packed struct
package sap_pkg;
`include "sap_defines.svh"

typedef logic [`SAP_WORD_W-1:0] sap_word_t;
typedef logic [`SAP_PTR_W-1:0] sap_ptr_t;
typedef logic [`SAP_CNT_W-1:0] sap_cnt_t;

typedef struct packed {
    logic [`SAP_CTL_W-1:0] ctl;
    logic [`SAP_CLK_W-1:0] clk;
    logic [8:0] div;
    logic [8:0] cyc;
    logic sclk;
    logic fs;
    logic sout;
    logic first;
    sap_word_t tsh;
    sap_word_t rsh;
    logic s1;
    logic s2;
    logic s3;
    logic sin;
    logic [31:0][`SAP_WORD_W-1:0] tmem;
    logic [31:0][`SAP_WORD_W-1:0] rmem;
    sap_ptr_t trp;
    sap_ptr_t rrp;
    sap_cnt_t tcnt;
    sap_cnt_t rcnt;
    logic [31:0] prdata;
    logic slverr;
} sap_state_s;

endpackage

/* testbench/sap_codec_model.sv */
// Purpose: Codec on the far side of the serial audio link
// Assumes: Link edges seen through pclk, so no race with the design's registers
// Notes: Plays a 17-bit pattern from sync, records 17 bits of serial_out
`timescale 1ns/1ps

module sap_codec_model (
    // Clock
    input wire logic pclk,
    // Link
    input wire logic shift_clock,
    input wire logic frame_sync,
    input wire logic serial_out,
    output logic serial_in,
    // Test side
    input wire logic [16:0] pattern,
    output logic [16:0] heard
);
    logic sc_prev;
    int cyc;

    initial begin
        serial_in = 1'b0;
        heard = 17'h00000;
        sc_prev = 1'b0;
        cyc = 99;
    end

    always @(posedge pclk) begin
        sc_prev <= shift_clock;
        if (shift_clock && !sc_prev) begin
            if (frame_sync) begin
                cyc = 0;
                heard <= 17'h00000;
            end else if (cyc < 99) begin
                cyc = cyc + 1;
            end
            // Outside the word, keep toggling so a stale level never looks right
            if (cyc <= 16) begin
                serial_in <= pattern[16 - cyc];
            end else begin
                serial_in <= ~serial_in;
            end
        end
        if (!shift_clock && sc_prev && cyc <= 16) begin
            heard <= {heard[15:0], serial_out};
        end
    end
endmodule

/* testbench/sap_ctrl_bench.sv */
// Purpose: Self-checking bench of the serial audio control block
// Assumes: Zero-wait APB slave; short divider values keep frames brief
// Notes: Reset and decode reads first, then table of control writes, then queue, flush and link cases
`timescale 1ns/1ps

module sap_ctrl_bench;
    import sap_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, shift_clock, frame_sync, serial_out, serial_in;
    logic tx_dma_req, rx_dma_req, tx_nearly_empty, tx_nearly_full;
    logic rx_nearly_empty, rx_nearly_full, rx_queue_empty;
    logic [16:0] pattern = 17'h13C96;
    logic [16:0] heard;
    logic [31:0] rdv;
    logic err;
    int errors = 0;
    int checked = 0;
    // Control write, readback, {tx_ne, tx_dma, rx_ne, rx_nf} with empty queues
    logic [31:0] row_wr [3] = '{32'h00004040, 32'h00001000, 32'hFFF80000};
    logic [31:0] row_rd [3] = '{32'h00004040, 32'h00001000, 32'h00000000};
    logic [3:0] row_fl [3] = '{4'hC, 4'h2, 4'h0};

    always #5 pclk = ~pclk;

    sap_ctrl sap_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .shift_clock(shift_clock),
        .frame_sync(frame_sync), .serial_out(serial_out), .serial_in(serial_in),
        .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
        .tx_nearly_empty(tx_nearly_empty), .tx_nearly_full(tx_nearly_full),
        .rx_nearly_empty(rx_nearly_empty), .rx_nearly_full(rx_nearly_full),
        .rx_queue_empty(rx_queue_empty));

    sap_codec_model sap_codec_model_i (.pclk(pclk), .shift_clock(shift_clock),
        .frame_sync(frame_sync), .serial_out(serial_out), .serial_in(serial_in),
        .pattern(pattern), .heard(heard));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Drives just after a rising edge and holds until pready is seen high at one
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rdv, exp);
    endtask

    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        give_verdict;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h00000000);
        rd(12'h018, 32'h00100000);
        rd(12'h01C, 32'h00000000);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h000, row_wr[i]);
            rd(12'h000, row_rd[i]);
            chk({tx_nearly_empty, tx_dma_req, rx_nearly_empty, rx_nearly_full},
                row_fl[i]);
        end
        // Threshold 4, tx queue and DMA on: sweep occupancy past full
        apb(1'b1, 12'h000, 32'h00008044);
        for (int n = 0; n <= 32; n++) begin
            chk({tx_nearly_empty, tx_nearly_full, tx_dma_req},
                {n < 4, n > 28, n <= 28});
            apb(1'b1, 12'h008, 32'h00000100 + n);
        end
        rd(12'h018, 32'h00120020);
        rd(12'h008, 32'h00010100);
        apb(1'b1, 12'h000, 32'h00008040);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        rd(12'h018, 32'h00110000);
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 12'h000, 32'h00001026 | (p * 32'h18));
            apb(1'b1, 12'h008, 32'h0000A5C3);
            apb(1'b1, 12'h004, 32'h00080E13);
            apb(1'b1, 12'h000, 32'h00001027 | (p * 32'h18));
            for (int t = 0; t < 2000 && rx_queue_empty !== 1'b0; t++) @(negedge pclk);
            chk({rx_dma_req, rx_nearly_full}, 32'h3);
            // Look before the next frame's sync clears what the codec heard
            repeat (30) @(negedge pclk);
            chk({15'h0, heard}, p ? 32'h0000A5C3 : 32'h00014B86);
            rd(12'h00C, 32'h00010000 | (p ? pattern[15:0] : pattern[16:1]));
            apb(1'b1, 12'h004, 32'h00000000);
            apb(1'b1, 12'h000, 32'h00000000);
            for (int t = 0; t < 40; t++) begin
                @(negedge pclk);
                chk({serial_out, frame_sync}, 32'h0);
            end
        end
        give_verdict;
    end
endmodule
